// ---- rtl/pes_top.sv ----
// performance event select with counters behind an axi4-lite slave
// Notes on behaviour
// - event 28H masks 01/02/04/08H count writebacks of I/S/E/M lines.
// - event 28H mask 0FH counts every L1 writeback to L2.
// - event 2EH mask 41H counts last-level cache misses.
// - event 2EH mask 4FH counts every last-level cache reference.
// - event 3CH mask 00H counts each clock while the thread runs.
// - event 3CH mask 01H counts fixed-rate ticks while the thread runs.
// - event 49H mask 01H counts second TLB misses starting a walk.
// - event 49H mask 02H counts second TLB misses with completed walk.
// - event 49H mask 04H counts every cycle a miss walk runs.
// - event 49H mask 10H counts first TLB misses hitting second TLB.
// - event 49H mask 20H counts misses from the low address part.
// - event 49H mask 80H counts completed large-page walks.
// - event 4CH mask 01H counts loads hitting pending prefetch; counters 0,1.
// - event 4EH mask 01H counts queue dispatches; counters 0,1 only.
// - event 4EH mask 02H counts prefetch misses from either prefetcher.
// - streamer stops after an L1 hit; pointer prefetcher keeps going.
// - event 4EH mask 04H counts pushes into the four-entry queue.
// - event 4FH mask 10H counts second-stage walk cycles.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
module pes_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic l1_writeback_i,
  input wire logic [1:0] l1_writeback_line_state_i,
  input wire logic last_level_cache_miss_i,
  input wire logic last_level_cache_access_i,
  input wire logic thread_halted_i,
  input wire logic second_tlb_miss_walk_start_i,
  input wire logic page_walk_done_i,
  input wire logic page_walk_active_i,
  input wire logic first_tlb_miss_second_hit_i,
  input wire logic low_address_translation_miss_i,
  input wire logic large_page_walk_done_i,
  input wire logic load_hit_pending_prefetch_i,
  input wire logic prefetch_queue_dispatch_i,
  input wire logic streamer_miss_i,
  input wire logic streamer_l1_hit_i,
  input wire logic streamer_start_i,
  input wire logic pointer_prefetch_miss_i,
  input wire logic prefetch_queue_push_i,
  input wire logic second_stage_walk_active_i,
  output logic irq_o
);
  // ******************************************
  // state
  // ******************************************
  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [pes_pkg::CNT_N-1:0][pes_pkg::CFG_W-1:0] cfg;
    logic [pes_pkg::CNT_N-1:0][31:0] cnt;
    logic [pes_pkg::CNT_N-1:0] sts;
    logic [pes_pkg::CNT_N-1:0] ien;
    logic irq;
    logic streamer_stopped;
  } pes_state_t;

  pes_state_t st;
  pes_state_t next_st;
  logic [pes_pkg::EV_W-1:0] ev;
  logic [pes_pkg::CNT_N-1:0] hit;
  logic [pes_pkg::CNT_N-1:0] cnt_wr;
  logic [pes_pkg::CNT_N-1:0] sts_clr;
  logic [pes_pkg::CNT_N-1:0] ovf;
  logic [31:0] wmask;
  logic [1:0] widx;
  logic [1:0] ridx;
  logic ref_tick;

  // ******************************************
  // event gathering
  // ******************************************
  // sources run on this clock, so they are read without synchronisers
  pes_ref_div u_ref_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_o(ref_tick)
  );

  assign ev[pes_pkg::EV_WB + 0] = l1_writeback_i && (l1_writeback_line_state_i == pes_pkg::LINE_I);
  assign ev[pes_pkg::EV_WB + 1] = l1_writeback_i && (l1_writeback_line_state_i == pes_pkg::LINE_S);
  assign ev[pes_pkg::EV_WB + 2] = l1_writeback_i && (l1_writeback_line_state_i == pes_pkg::LINE_E);
  assign ev[pes_pkg::EV_WB + 3] = l1_writeback_i && (l1_writeback_line_state_i == pes_pkg::LINE_M);
  assign ev[pes_pkg::EV_LLC_MISS] = last_level_cache_miss_i;
  // a miss is a reference too
  assign ev[pes_pkg::EV_LLC_REF] = last_level_cache_access_i || last_level_cache_miss_i;
  assign ev[pes_pkg::EV_UNHALT] = !thread_halted_i;
  // fixed rate of one tick per REF_CYC cycles of clk_i, so it follows this clock's scaling
  assign ev[pes_pkg::EV_REFCYC] = ref_tick && !thread_halted_i;
  // translation events in unit-mask bit order
  assign ev[pes_pkg::EV_TRANS + 0] = second_tlb_miss_walk_start_i;
  assign ev[pes_pkg::EV_TRANS + 1] = page_walk_done_i;
  assign ev[pes_pkg::EV_TRANS + 2] = page_walk_active_i;
  assign ev[pes_pkg::EV_TRANS + 3] = 1'b0;
  assign ev[pes_pkg::EV_TRANS + 4] = first_tlb_miss_second_hit_i;
  assign ev[pes_pkg::EV_TRANS + 5] = low_address_translation_miss_i;
  assign ev[pes_pkg::EV_TRANS + 6] = 1'b0;
  assign ev[pes_pkg::EV_TRANS + 7] = large_page_walk_done_i;
  assign ev[pes_pkg::EV_LOAD_PRE] = load_hit_pending_prefetch_i;
  assign ev[pes_pkg::EV_PF + 0] = prefetch_queue_dispatch_i;
  // either prefetcher; a stopped streamer misses nothing
  assign ev[pes_pkg::EV_PF + 1] = (streamer_miss_i && !st.streamer_stopped) || pointer_prefetch_miss_i;
  // pushes, counted even if later dropped
  assign ev[pes_pkg::EV_PF + 2] = prefetch_queue_push_i;
  assign ev[pes_pkg::EV_STAGE2] = second_stage_walk_active_i;

  // one decoder per counter
  for (genvar g = 0; g < pes_pkg::CNT_N; g++) begin : g_match
    pes_event_match #(
      .IDX(g)
    ) u_match (
      .ev_i(ev),
      .code_i(st.cfg[g][7:0]),
      .umask_i(st.cfg[g][15:8]),
      .hit_o(hit[g])
    );
  end

  // ******************************************
  // next state
  // ******************************************
  // byte lanes of the pending write
  assign wmask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
  assign widx = st.awaddr[5:4];
  assign ridx = s_axi_araddr_i[5:4];

  // bus slave, counters, interrupt status and streamer flag
  always_comb begin
    next_st = st;
    cnt_wr = '0;
    sts_clr = '0;
    ovf = '0;
    // address and data are taken independently, in any order
    if (st.aw_rdy && s_axi_awvalid_i) begin
      next_st.aw_have = 1'b1;
      next_st.awaddr = s_axi_awaddr_i;
    end
    if (st.w_rdy && s_axi_wvalid_i) begin
      next_st.w_have = 1'b1;
      next_st.wdata = s_axi_wdata_i;
      next_st.wstrb = s_axi_wstrb_i;
    end
    if (st.bvalid && s_axi_bready_i) begin
      next_st.bvalid = 1'b0;
    end
    // perform the write once both halves are held
    if (st.aw_have && st.w_have && !st.bvalid) begin
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = pes_pkg::RESP_OKAY;
      if (st.awaddr[7:6] == pes_pkg::BANK_CNT && st.awaddr[3:0] == pes_pkg::CFG_OFS) begin
        next_st.cfg[widx] = pes_pkg::CFG_W'((st.wdata & wmask) | (32'(st.cfg[widx]) & ~wmask));
      end else if (st.awaddr[7:6] == pes_pkg::BANK_CNT && st.awaddr[3:0] == pes_pkg::CNT_OFS) begin
        cnt_wr[widx] = 1'b1;
        next_st.cnt[widx] = (st.wdata & wmask) | (st.cnt[widx] & ~wmask);
      end else if (st.awaddr == pes_pkg::IRQ_EN_OFS) begin
        next_st.ien = pes_pkg::CNT_N'((st.wdata & wmask) | (32'(st.ien) & ~wmask));
      end else if (st.awaddr == pes_pkg::IRQ_CLR_OFS) begin
        sts_clr = pes_pkg::CNT_N'(st.wdata & wmask);
      end else if (st.awaddr != pes_pkg::IRQ_STS_OFS) begin
        next_st.bresp = pes_pkg::RESP_SLVERR;
      end
    end
    // read answers one cycle after the address is taken
    if (st.rvalid && s_axi_rready_i) begin
      next_st.rvalid = 1'b0;
    end
    if (st.ar_rdy && s_axi_arvalid_i) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = pes_pkg::RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      if (s_axi_araddr_i[7:6] == pes_pkg::BANK_CNT && s_axi_araddr_i[3:0] == pes_pkg::CFG_OFS) begin
        next_st.rdata = 32'(st.cfg[ridx]);
      end else if (s_axi_araddr_i[7:6] == pes_pkg::BANK_CNT && s_axi_araddr_i[3:0] == pes_pkg::CNT_OFS) begin
        next_st.rdata = st.cnt[ridx];
      end else if (s_axi_araddr_i == pes_pkg::IRQ_STS_OFS) begin
        next_st.rdata = 32'(st.sts);
      end else if (s_axi_araddr_i == pes_pkg::IRQ_EN_OFS) begin
        next_st.rdata = 32'(st.ien);
      end else if (s_axi_araddr_i != pes_pkg::IRQ_CLR_OFS) begin
        next_st.rresp = pes_pkg::RESP_SLVERR;
      end
    end
    // only one write and one read in flight: ready drops until the answer is taken
    next_st.aw_rdy = !next_st.aw_have && !next_st.bvalid;
    next_st.w_rdy = !next_st.w_have && !next_st.bvalid;
    next_st.ar_rdy = !next_st.rvalid;
    // hit already merges the selected bits; a software write beats a count
    for (int i = 0; i < pes_pkg::CNT_N; i++) begin
      if (!cnt_wr[i] && st.cfg[i][pes_pkg::CFG_EN_BIT] && hit[i]) begin
        next_st.cnt[i] = st.cnt[i] + 32'h0000_0001;
        ovf[i] = (st.cnt[i] == 32'hffff_ffff);
      end
    end
    // an overflow in the clearing cycle is kept
    next_st.sts = (st.sts & ~sts_clr) | ovf;
    next_st.irq = |(next_st.sts & next_st.ien);
    // streamer halts on a hit, resumes on a new stream
    if (streamer_l1_hit_i) begin
      next_st.streamer_stopped = 1'b1;
    end else if (streamer_start_i) begin
      next_st.streamer_stopped = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************
  // outputs
  // ******************************************
  assign s_axi_awready_o = st.aw_rdy;
  assign s_axi_wready_o = st.w_rdy;
  assign s_axi_bvalid_o = st.bvalid;
  assign s_axi_bresp_o = st.bresp;
  assign s_axi_arready_o = st.ar_rdy;
  assign s_axi_rvalid_o = st.rvalid;
  assign s_axi_rdata_o = st.rdata;
  assign s_axi_rresp_o = st.rresp;
  assign irq_o = st.irq;

  // ******************************************
  // checks
  // ******************************************
  // counter 0 is the observed channel; writes to it are masked out
  logic [7:0] ev0;
  logic [7:0] um0;
  logic run0;
  assign ev0 = st.cfg[0][7:0];
  assign um0 = st.cfg[0][15:8];
  assign run0 = st.cfg[0][pes_pkg::CFG_EN_BIT] && !cnt_wr[0];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_WB_INVALID: assert property (
    (run0 && ev0 == 8'h28 && um0 == 8'h01 && l1_writeback_i && l1_writeback_line_state_i == 2'h0)
    |=> st.cnt[0] == $past(st.cnt[0]) + 32'h1)
    else $error("invalid-line writeback not counted");
  AST_WB_WRONG_STATE: assert property (
    (run0 && ev0 == 8'h28 && um0 == 8'h02 && !(l1_writeback_i && l1_writeback_line_state_i == 2'h1))
    |=> $stable(st.cnt[0]))
    else $error("shared-line count moved without a shared writeback");
  AST_WB_ANY: assert property (
    (run0 && ev0 == 8'h28 && um0 == 8'h0f && l1_writeback_i) |=> st.cnt[0] == $past(st.cnt[0]) + 32'h1)
    else $error("writeback of any state not counted");
  AST_LLC_MISS: assert property (
    (run0 && ev0 == 8'h2e && um0 == 8'h41) |=> st.cnt[0] == $past(st.cnt[0]) + 32'($past(last_level_cache_miss_i)))
    else $error("llc miss count wrong");
  AST_THREAD_RUN: assert property (
    (run0 && ev0 == 8'h3c && um0 == 8'h00 && !thread_halted_i)[*3] |=> st.cnt[0] == $past(st.cnt[0], 3) + 32'h3)
    else $error("running thread cycles not counted each clock");
  AST_REF_HALTED: assert property (
    (run0 && ev0 == 8'h3c && um0 == 8'h01 && thread_halted_i) |=> $stable(st.cnt[0]))
    else $error("reference cycles counted while halted");
  AST_REF_RATE: assert property (
    ref_tick |=> !ref_tick [*8])
    else $error("reference tick faster than its period");
  AST_WALK_CYCLES: assert property (
    (run0 && ev0 == 8'h49 && um0 == 8'h04 && page_walk_active_i) |=> st.cnt[0] == $past(st.cnt[0]) + 32'h1)
    else $error("walk cycle not counted");
  AST_HIGH_CNT_PREFETCH: assert property (
    (st.cfg[2][7:0] == 8'h4e && !cnt_wr[2]) |=> $stable(st.cnt[2]))
    else $error("counter 2 counted a low-counter-only event");
  AST_STREAMER_STOP: assert property (
    streamer_l1_hit_i |=> st.streamer_stopped
      && !(streamer_miss_i && !pointer_prefetch_miss_i && ev[pes_pkg::EV_PF + 1]))
    else $error("stopped streamer still counted");
  AST_ANY_BIT: assert property (
    (run0 && ev0 == 8'h49 && um0 == 8'h03 && (second_tlb_miss_walk_start_i || page_walk_done_i))
    |=> st.cnt[0] == $past(st.cnt[0]) + 32'h1)
    else $error("combined mask missed a condition");
  AST_IRQ_LEVEL: assert property (
    ##1 irq_o == |($past(next_st.sts) & $past(next_st.ien)))
    else $error("interrupt does not follow enabled status");

  COV_OVERFLOW_IRQ: cover property (ovf[0] ##1 irq_o);
  COV_WRITE: cover property (s_axi_bvalid_o && s_axi_bready_i);
  COV_READ: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule : pes_top

// ---- rtl/pes_pkg.sv ----
// constants shared by the performance event select block
package pes_pkg;
  // ******************************************
  // counters and register map
  // ******************************************
  localparam int CNT_N = 4;
  localparam int CFG_W = 17;
  localparam int CFG_EN_BIT = 16;
  localparam logic [1:0] BANK_CNT = 2'h0;
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] CNT_OFS = 4'h4;
  localparam logic [7:0] IRQ_STS_OFS = 8'h40;
  localparam logic [7:0] IRQ_EN_OFS = 8'h44;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h48;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ******************************************
  // event numbers and unit masks
  // ******************************************
  localparam logic [7:0] EVT_WRITEBACK = 8'h28;
  localparam logic [7:0] EVT_LLC = 8'h2e;
  localparam logic [7:0] EVT_UNHALTED = 8'h3c;
  localparam logic [7:0] EVT_TRANSLATE = 8'h49;
  localparam logic [7:0] EVT_LOAD_PRE = 8'h4c;
  localparam logic [7:0] EVT_PREFETCH = 8'h4e;
  localparam logic [7:0] EVT_STAGE2 = 8'h4f;
  localparam logic [7:0] UM_LLC_MISS = 8'h41;
  localparam logic [7:0] UM_LLC_REF = 8'h4f;
  localparam logic [7:0] UM_THREAD = 8'h00;
  localparam logic [7:0] UM_REF = 8'h01;
  localparam logic [7:0] UM_LOAD_PRE = 8'h01;
  localparam logic [7:0] UM_STAGE2 = 8'h10;
  // ******************************************
  // line states of a writeback
  // ******************************************
  localparam logic [1:0] LINE_I = 2'h0;
  localparam logic [1:0] LINE_S = 2'h1;
  localparam logic [1:0] LINE_E = 2'h2;
  localparam logic [1:0] LINE_M = 2'h3;
  // ******************************************
  // event vector bit positions
  // ******************************************
  localparam int EV_WB = 0;
  localparam int EV_LLC_MISS = 4;
  localparam int EV_LLC_REF = 5;
  localparam int EV_UNHALT = 6;
  localparam int EV_REFCYC = 7;
  localparam int EV_TRANS = 8;
  localparam int EV_LOAD_PRE = 16;
  localparam int EV_PF = 17;
  localparam int EV_STAGE2 = 20;
  localparam int EV_W = 21;
  // ******************************************
  // reference tick timing
  // ******************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_PERIOD_NS = 100;
  localparam int REF_CYC = REF_PERIOD_NS / CLK_PERIOD_NS;
endpackage : pes_pkg

// ---- rtl/pes_ref_div.sv ----
// divider making the fixed-rate reference tick
module pes_ref_div (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  output logic tick_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } pes_div_t;
  pes_div_t st;
  pes_div_t next_st;

  // count up one reference period, pulse at the wrap
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 8'(pes_pkg::REF_CYC - 1)) begin
      next_st.cnt = 8'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;
endmodule : pes_ref_div

// ---- rtl/pes_event_match.sv ----
// decodes one counter's event select into a count pulse
module pes_event_match #(
  parameter int IDX = 0
) (
  input wire logic [pes_pkg::EV_W-1:0] ev_i,
  input wire logic [7:0] code_i,
  input wire logic [7:0] umask_i,
  output logic hit_o
);
  // the prefetch and load-hit events exist on the two low counters only
  localparam bit LOW_CNT = (IDX < 2);
  logic [7:0] trans;

  // translation unit-mask bits line up with the event vector
  assign trans = ev_i[pes_pkg::EV_TRANS +: 8];

  // select the condition; writeback, translation and prefetch count on any chosen unit-mask bit, the rest need an exact mask
  always_comb begin
    hit_o = 1'b0;
    case (code_i)
      pes_pkg::EVT_WRITEBACK: begin
        hit_o = (umask_i[7:4] == 4'h0) && |(umask_i[3:0] & ev_i[pes_pkg::EV_WB +: 4]);
      end
      pes_pkg::EVT_LLC: begin
        if (umask_i == pes_pkg::UM_LLC_MISS) begin
          hit_o = ev_i[pes_pkg::EV_LLC_MISS];
        end else if (umask_i == pes_pkg::UM_LLC_REF) begin
          hit_o = ev_i[pes_pkg::EV_LLC_REF];
        end
      end
      pes_pkg::EVT_UNHALTED: begin
        if (umask_i == pes_pkg::UM_THREAD) begin
          hit_o = ev_i[pes_pkg::EV_UNHALT];
        end else if (umask_i == pes_pkg::UM_REF) begin
          hit_o = ev_i[pes_pkg::EV_REFCYC];
        end
      end
      pes_pkg::EVT_TRANSLATE: begin
        hit_o = |(umask_i & trans);
      end
      pes_pkg::EVT_LOAD_PRE: begin
        hit_o = LOW_CNT && (umask_i == pes_pkg::UM_LOAD_PRE) && ev_i[pes_pkg::EV_LOAD_PRE];
      end
      pes_pkg::EVT_PREFETCH: begin
        hit_o = LOW_CNT && (umask_i[7:3] == 5'h00) && |(umask_i[2:0] & ev_i[pes_pkg::EV_PF +: 3]);
      end
      pes_pkg::EVT_STAGE2: begin
        hit_o = (umask_i == pes_pkg::UM_STAGE2) && ev_i[pes_pkg::EV_STAGE2];
      end
      default: begin
        hit_o = 1'b0;
      end
    endcase
  end
endmodule : pes_event_match

// ---- tb/pes_src_model.sv ----
// event source model standing in for the core cache, tlb and prefetch logic
module pes_src_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [4:0] sel_i,
  input wire logic [1:0] st_i,
  input wire logic hlt_i,
  output logic [16:0] ev_o = 17'h0,
  output logic [1:0] st_o = 2'h0,
  output logic halted_o = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  // one event line high per cycle of go; line state is only valid with a writeback,
  // so it shows the inverse of the last value when idle
  always @(posedge clk_i) begin
    ev_o <= go_i ? (17'h1 << sel_i) : 17'h0;
    st_o <= go_i ? st_i : ~st_o;
    halted_o <= hlt_i;
  end
endmodule : pes_src_model

// ---- tb/pes_top_tb.sv ----
// self-checking bench for the performance event select block
module pes_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ******************************************
  // signals
  // ******************************************
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rv, rdata;
  logic [1:0] rr, br, bresp, rresp, st = 2'h0, st_m;
  logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, irq, go = 1'b0, halt_instruction = 1'b1, halted;
  logic [4:0] sel = 5'h0;
  logic [16:0] ev;
  int bad_count = 0, cmp_count = 0, cyc = 0;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
  // ******************************************
  // design and event sources
  // ******************************************
  pes_src_model pes_src_model_i (.clk_i(clk_i), .go_i(go), .sel_i(sel), .st_i(st), .hlt_i(halt_instruction),
    .ev_o(ev), .st_o(st_m), .halted_o(halted));
  pes_top pes_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(w_rdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(ar_rdy),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .l1_writeback_i(ev[0]), .l1_writeback_line_state_i(st_m), .last_level_cache_miss_i(ev[1]),
    .last_level_cache_access_i(ev[2]), .thread_halted_i(halted), .second_tlb_miss_walk_start_i(ev[3]),
    .page_walk_done_i(ev[4]), .page_walk_active_i(ev[5]), .first_tlb_miss_second_hit_i(ev[6]),
    .low_address_translation_miss_i(ev[7]), .large_page_walk_done_i(ev[8]),
    .load_hit_pending_prefetch_i(ev[9]), .prefetch_queue_dispatch_i(ev[10]), .streamer_miss_i(ev[11]),
    .streamer_l1_hit_i(ev[12]), .streamer_start_i(ev[13]), .pointer_prefetch_miss_i(ev[14]),
    .prefetch_queue_push_i(ev[15]), .second_stage_walk_active_i(ev[16]), .irq_o(irq));
  // ******************************************
  // clock, timeout, verdict
  // ******************************************
  // free-running 100 MHz clock
  always #5 clk_i = ~clk_i;
  // a hang anywhere ends the run well past the expected length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // ******************************************
  // bus and stimulus tasks
  // ******************************************
  // each half is released once taken; no cycle count is assumed for the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk_i);
      ta = ta | (aw_rdy === 1'b1);
      tw = tw | (w_rdy === 1'b1);
      awv <= !ta;
      wv <= !tw;
    end
    while (bvalid !== 1'b1) @(posedge clk_i);
    br = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (ar_rdy !== 1'b1);
    arv <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_i);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rdc(input int n);
    rd(8'(n * 16 + 4));
  endtask : rdc
  // config first, then clear, so the count starts from zero
  task automatic arm(input int n, input logic [7:0] e, input logic [7:0] m);
    wr(8'(n * 16), {15'h0, 1'b1, m, e});
    wr(8'(n * 16 + 4), 32'h0);
  endtask : arm
  // event line s high for k cycles, then a quiet gap
  task automatic fire(input int s, input int k, input logic [1:0] ls);
    @(posedge clk_i);
    sel <= 5'(s);
    st <= ls;
    go <= 1'b1;
    repeat (k) @(posedge clk_i);
    go <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : fire
  // thread runs for exactly k cycles
  task automatic run(input int k);
    @(posedge clk_i);
    halt_instruction <= 1'b0;
    repeat (k) @(posedge clk_i);
    halt_instruction <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : run
  // ******************************************
  // scenarios
  // ******************************************
  task automatic t_rst;
    rd(8'h00);
    `CHK(rv, 32'h0)
    rd(8'h4c);
    `CHK(rr, pes_pkg::RESP_SLVERR)
    wr(8'h4c, 32'h1);
    `CHK(br, pes_pkg::RESP_SLVERR)
  endtask : t_rst
  // one writeback in each line state; single masks see one, the full mask all four
  task automatic t_wb;
    logic [7:0] um [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0f};
    for (int i = 0; i < 5; i++) begin
      arm(0, pes_pkg::EVT_WRITEBACK, um[i]);
      for (int s = 0; s < 4; s++) fire(0, 1, 2'(s));
      rdc(0);
      `CHK(rv, (i < 4) ? 32'h1 : 32'h4)
    end
  endtask : t_wb
  task automatic t_llc;
    for (int i = 0; i < 2; i++) begin
      arm(0, pes_pkg::EVT_LLC, i ? pes_pkg::UM_LLC_REF : pes_pkg::UM_LLC_MISS);
      fire(1, 1, 2'h0);
      fire(2, 2, 2'h0);
      rdc(0);
      `CHK(rv, i ? 32'h3 : 32'h1)
    end
  endtask : t_llc
  // a 100-cycle run holds exactly ten reference ticks whatever their phase
  task automatic t_cyc;
    arm(0, pes_pkg::EVT_UNHALTED, pes_pkg::UM_THREAD);
    arm(2, pes_pkg::EVT_UNHALTED, pes_pkg::UM_THREAD);
    run(20);
    rdc(0);
    `CHK(rv, 32'd20)
    rdc(2);
    `CHK(rv, 32'd20)
    arm(0, pes_pkg::EVT_UNHALTED, pes_pkg::UM_REF);
    run(100);
    rdc(0);
    `CHK(rv, 32'd10)
  endtask : t_cyc
  // matching source two cycles, a neighbouring source once
  task automatic t_tlb;
    logic [7:0] um [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h80};
    for (int i = 0; i < 6; i++) begin
      arm(0, pes_pkg::EVT_TRANSLATE, um[i]);
      fire(i + 3, 2, 2'h0);
      fire(i == 5 ? 3 : i + 4, 1, 2'h0);
      rdc(0);
      `CHK(rv, 32'h2)
    end
    // two selected conditions each count, an unselected one does not
    arm(0, pes_pkg::EVT_TRANSLATE, 8'h03);
    fire(3, 1, 2'h0);
    fire(4, 1, 2'h0);
    fire(5, 1, 2'h0);
    rdc(0);
    `CHK(rv, 32'h2)
    arm(3, pes_pkg::EVT_STAGE2, pes_pkg::UM_STAGE2);
    fire(16, 3, 2'h0);
    fire(5, 1, 2'h0);
    rdc(3);
    `CHK(rv, 32'h3)
  endtask : t_tlb
  // prefetch events count on counter 0 but never on counter 2
  task automatic t_pf;
    int sl [3] = '{9, 10, 15};
    logic [7:0] ev_n [3] = '{8'h4c, 8'h4e, 8'h4e};
    logic [7:0] um [3] = '{8'h01, 8'h01, 8'h04};
    for (int i = 0; i < 3; i++) begin
      arm(0, ev_n[i], um[i]);
      arm(2, ev_n[i], um[i]);
      fire(sl[i], 1, 2'h0);
      rdc(0);
      `CHK(rv, 32'h1)
      rdc(2);
      `CHK(rv, 32'h0)
    end
    arm(1, pes_pkg::EVT_PREFETCH, 8'h02);
    fire(11, 1, 2'h0);
    fire(12, 1, 2'h0);
    fire(11, 1, 2'h0);
    rdc(1);
    `CHK(rv, 32'h1)
    fire(14, 1, 2'h0);
    fire(13, 1, 2'h0);
    fire(11, 1, 2'h0);
    rdc(1);
    `CHK(rv, 32'h3)
  endtask : t_pf
  // overflow sets a sticky bit; the line follows only while enabled
  task automatic t_irq;
    arm(1, pes_pkg::EVT_UNHALTED, pes_pkg::UM_THREAD);
    wr(8'h14, 32'hffffffff);
    run(1);
    rd(pes_pkg::IRQ_STS_OFS);
    `CHK(rv, 32'h2)
    `CHK(irq, 1'b0)
    wr(pes_pkg::IRQ_EN_OFS, 32'h2);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b1)
    wr(pes_pkg::IRQ_CLR_OFS, 32'h2);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b0)
    rd(pes_pkg::IRQ_STS_OFS);
    `CHK(rv, 32'h0)
  endtask : t_irq
  // ******************************************
  // main sequence
  // ******************************************
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_rst();
    t_wb();
    t_llc();
    t_cyc();
    t_tlb();
    t_pf();
    t_irq();
    close_out();
  end
endmodule : pes_top_tb
